// *** inc/burst_sram_consts.svh ***
// timing and field constants for the burst sram control block
// assumes inclusion once per compile unit; guarded
`ifndef BURST_SRAM_CONSTS_SVH
`define BURST_SRAM_CONSTS_SVH
`define BURST_ADDR_LO_W 2
`define BURST_LEN 3'h4
`define BURST_STEP_ONE 2'h1
`define LANE_COUNT_WIDE 4
`define LANE_COUNT_NARROW 2
`define ORG_WIDE_BITS 36
`endif

// *** inc/burst_sram_pkg.sv ***
// types shared by the burst sram control block
// assumes nothing beyond a systemverilog compiler
package burst_sram_pkg;
   // decoded synchronous cycle kind, one-hot
   typedef enum logic [4:0] {
      CYC_DESELECT = 5'h01,
      CYC_BEGIN_RD = 5'h02,
      CYC_BEGIN_WR = 5'h04,
      CYC_CONTINUE = 5'h08,
      CYC_SUSPEND  = 5'h10
   } cycle_kind_t;
endpackage

// *** src/burst_addr_gen.sv ***
// burst counter: low address bits in linear or interleaved order
// assumes load and step are sampled on the clock edge; order acts on the output combinationally
`timescale 1ns/100ps
`include "burst_sram_consts.svh"
module burst_addr_gen
   import burst_sram_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic load,
   input wire logic step,
   input wire logic interleave,
   input wire logic [1:0] start_bits,
   output logic [1:0] addr_bits
);
   typedef struct packed {
      logic [1:0] start;
      logic [1:0] count;
   } ctr_state_t;
   ctr_state_t s_q, s_d;

   // load presets start, step bumps count, else hold
   always_comb begin
      s_d = s_q;
      if (load) begin
         s_d.start = start_bits;
         s_d.count = 2'h0;
      end else if (step) begin
         s_d.count = s_q.count + `BURST_STEP_ONE; // wraps on fifth beat
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // order select: add for linear, xor for interleaved
   always_comb begin
      if (interleave) begin
         addr_bits = s_q.start ^ s_q.count;
      end else begin
         addr_bits = s_q.start + s_q.count;
      end
   end

   chk_linear_step: assert property (@(posedge clk) disable iff (reset)
      step && !load && !interleave |=> addr_bits == $past(addr_bits) + 2'h1)
      else $error("linear burst did not step by one");
   chk_inter_wrap: assert property (@(posedge clk) disable iff (reset)
      load ##1 (step && !load && interleave) [*4] |=> addr_bits == $past(start_bits, 5))
      else $error("interleaved burst did not wrap to start");
endmodule

// *** src/lane_write_decode.sv ***
// byte-lane write decode from global, gate and per-lane enables
// assumes all enables active low and sampled with the cycle
`timescale 1ns/100ps
`include "burst_sram_consts.svh"
module lane_write_decode
   import burst_sram_pkg::*;
#(
   parameter int LANES = `LANE_COUNT_WIDE
) (
   input wire logic all_lane_write_n,
   input wire logic lane_write_gate_n,
   input wire logic [LANES-1:0] lane_write_n,
   output logic [LANES-1:0] lane_we,
   output logic write_flag
);
   // per-lane enable: global forces all, gate selects low lanes
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      assign lane_we[i] = !all_lane_write_n || (!lane_write_gate_n && !lane_write_n[i]);
   end
   assign write_flag = |lane_we;
endmodule

// *** src/sync_burst_sram_control.sv ***
// synchronous control of a burst static ram: cycle decode, burst counter, lane writes
// assumes controller inputs synchronous to clk; output enable is asynchronous
`timescale 1ns/100ps
`include "burst_sram_consts.svh"
// Operation
// - linear order steps low address bits plus one modulo four.
// - interleaved order xors start with count, back to start on fifth clock.
// - global write low writes every lane.
// - gate low writes lanes whose enables are low; otherwise read.
// - reads drive all lanes; writes keep all lanes high impedance.
// - upper two lanes exist only in the 36-bit organisation.
// - any selected lane makes the cycle a write; the code keeps a processor-strobe begin a read.
// - chip select high with controller strobe low deselects; data high impedance.
// - processor strobe, or controller strobe with no write, begins a read burst.
// - controller strobe with write flag loads address and writes first beat.
// - both strobes high, advance low, no write: step and read next.
// - same continue conditions with write: step and write next.
// - controller strobe high, advance high, no write: hold and reread.
// - controller strobe high, advance high, write: hold and rewrite.
// - output enable high turns drivers off at once; low only re-enables reads.
// - reads with output enable high still advance the counter.
// - order select low is linear, high interleaved.
// - two lowest address inputs feed address and counter preset.
module sync_burst_sram_control
   import burst_sram_pkg::*;
#(
   parameter int DATA_BITS = `ORG_WIDE_BITS,
   parameter int LANES = (DATA_BITS == `ORG_WIDE_BITS) ? `LANE_COUNT_WIDE : `LANE_COUNT_NARROW
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic chip_select_n,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_step_n,
   input wire logic all_lane_write_n,
   input wire logic lane_write_gate_n,
   input wire logic [LANES-1:0] lane_write_n,
   input wire logic burst_order_sel_n,
   input wire logic output_enable_n,
   input wire logic [1:0] addr_low_bits,
   output logic [1:0] burst_addr,
   output logic [LANES-1:0] lane_write_en,
   output logic mem_read,
   output logic [LANES-1:0] lane_drive_en,
   output logic cycle_active,
   output cycle_kind_t cycle_kind
);
   typedef struct packed {
      logic [LANES-1:0] we;
      logic rd;
      logic drive;
      logic active;
      cycle_kind_t kind;
   } ctl_state_t;
   ctl_state_t s_q, s_d;

   logic [LANES-1:0] lane_we;
   logic write_flag;
   logic ctr_load;
   logic ctr_step;
   cycle_kind_t kind_now;

   // lane decode; narrow organisations simply have fewer lanes
   lane_write_decode #(
      .LANES(LANES)
   ) u_lanes (
      .all_lane_write_n(all_lane_write_n),
      .lane_write_gate_n(lane_write_gate_n),
      .lane_write_n(lane_write_n),
      .lane_we(lane_we),
      .write_flag(write_flag)
   );

   // decode check sits here, where a clock is available
   chk_global_all: assert property (@(posedge clk) disable iff (reset)
      !all_lane_write_n |-> &lane_we)
      else $error("global write missed a lane");

   // synchronous cycle decode, deselect first
   always_comb begin
      if (chip_select_n && !ctrl_addr_strobe_n) begin
         kind_now = CYC_DESELECT;
      end else if (!chip_select_n && !proc_addr_strobe_n) begin
         kind_now = CYC_BEGIN_RD;
      end else if (!chip_select_n && !ctrl_addr_strobe_n) begin
         kind_now = write_flag ? CYC_BEGIN_WR : CYC_BEGIN_RD;
      end else if (!burst_step_n) begin
         kind_now = CYC_CONTINUE;
      end else begin
         kind_now = CYC_SUSPEND;
      end
   end

   // counter load on any begin, step on continue regardless of output enable
   assign ctr_load = (kind_now == CYC_BEGIN_RD) || (kind_now == CYC_BEGIN_WR);
   assign ctr_step = (kind_now == CYC_CONTINUE);

   burst_addr_gen u_ctr (
      .clk(clk),
      .reset(reset),
      .load(ctr_load),
      .step(ctr_step),
      .interleave(burst_order_sel_n),
      .start_bits(addr_low_bits),
      .addr_bits(burst_addr)
   );

   // next registered cycle state; begin-read ignores write inputs
   always_comb begin
      s_d = s_q;
      s_d.kind = kind_now;
      s_d.active = (kind_now != CYC_DESELECT);
      if (kind_now == CYC_DESELECT || kind_now == CYC_BEGIN_RD && !proc_addr_strobe_n) begin
         s_d.we = '0;
         s_d.rd = (kind_now == CYC_BEGIN_RD);
      end else begin
         s_d.we = lane_we;
         s_d.rd = !write_flag;
      end
      s_d.drive = s_d.active && s_d.rd;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= '{we: '0, rd: 1'b0, drive: 1'b0, active: 1'b0, kind: CYC_DESELECT};
      end else begin
         s_q <= s_d;
      end
   end

   // outputs; output enable gates drivers with no clock
   assign lane_write_en = s_q.we;
   assign mem_read = s_q.rd && s_q.active;
   assign cycle_active = s_q.active;
   assign cycle_kind = s_q.kind;
   assign lane_drive_en = {LANES{s_q.drive && !output_enable_n}};

   chk_write_hiz: assert property (@(posedge clk) disable iff (reset)
      |lane_write_en |-> lane_drive_en == '0)
      else $error("lanes driven during write");
   chk_deselect_idle: assert property (@(posedge clk) disable iff (reset)
      chip_select_n && !ctrl_addr_strobe_n |=> !cycle_active && lane_drive_en == '0 && lane_write_en == '0)
      else $error("deselect left cycle active");
   chk_begin_write: assert property (@(posedge clk) disable iff (reset)
      !chip_select_n && proc_addr_strobe_n && !ctrl_addr_strobe_n && write_flag
      |=> lane_write_en == $past(lane_we) && cycle_kind == CYC_BEGIN_WR && burst_addr == $past(addr_low_bits))
      else $error("begin write not taken");
   chk_proc_read: assert property (@(posedge clk) disable iff (reset)
      !chip_select_n && !proc_addr_strobe_n |=> mem_read && lane_write_en == '0)
      else $error("processor strobe did not start read");
   chk_suspend_hold: assert property (@(posedge clk) disable iff (reset)
      ctrl_addr_strobe_n && !burst_step_n
      ##1 ctrl_addr_strobe_n && burst_step_n && (proc_addr_strobe_n || chip_select_n)
      |=> $stable(burst_addr))
      else $error("suspend moved the counter");
   chk_dummy_step: assert property (@(posedge clk) disable iff (reset)
      output_enable_n && ctrl_addr_strobe_n && proc_addr_strobe_n && !burst_step_n && !write_flag && !burst_order_sel_n
      ##1 output_enable_n |-> burst_addr == $past(burst_addr) + 2'h1 && lane_drive_en == '0)
      else $error("dummy read did not advance");
   chk_continue_write: assert property (@(posedge clk) disable iff (reset)
      ctrl_addr_strobe_n && proc_addr_strobe_n && !burst_step_n && write_flag
      |=> cycle_kind == CYC_CONTINUE && lane_write_en != '0)
      else $error("continue write lost");
   chk_oe_async: assert property (@(posedge clk) disable iff (reset)
      output_enable_n |-> lane_drive_en == '0)
      else $error("drivers on with output enable high");

   cov_burst_read: cover property (@(posedge clk) disable iff (reset)
      cycle_kind == CYC_BEGIN_RD ##1 cycle_kind == CYC_CONTINUE [*3]);
   cov_burst_write: cover property (@(posedge clk) disable iff (reset)
      cycle_kind == CYC_BEGIN_WR ##1 cycle_kind == CYC_CONTINUE);
   cov_dummy_to_write: cover property (@(posedge clk) disable iff (reset)
      mem_read && output_enable_n ##1 |lane_write_en);
   cov_suspend: cover property (@(posedge clk) disable iff (reset) cycle_kind == CYC_SUSPEND);
endmodule

// *** tb/ctrl_model.sv ***
// controller model: issues one synchronous memory cycle per clock
// assumes the bench calls drive() once per cycle; inputs change at falling edge
`timescale 1ns/100ps
module ctrl_model (
   input wire logic clk,
   output logic chip_select_n,
   output logic proc_addr_strobe_n,
   output logic ctrl_addr_strobe_n,
   output logic burst_step_n,
   output logic all_lane_write_n,
   output logic lane_write_gate_n,
   output logic [3:0] lane_write_n,
   output logic [1:0] addr_low_bits
);
   // idle: deselected, processor strobe parked high, controller strobe low
   initial begin
      {chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n} = 3'h6;
      {burst_step_n, all_lane_write_n, lane_write_gate_n} = 3'h7;
      lane_write_n = 4'hf;
      addr_low_bits = 2'h0;
   end
   // one cycle: {cs, proc, ctrl, step, global, gate} held until next call
   task automatic drive(input logic [5:0] c, input logic [3:0] ln, input logic [1:0] a);
      @(negedge clk);
      {chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n} = c[5:3];
      {burst_step_n, all_lane_write_n, lane_write_gate_n} = c[2:0];
      lane_write_n = ln;
      addr_low_bits = a;
   endtask
endmodule

// *** tb/tb_top.sv ***
// bench for the burst sram control block: cycle sequences with expected outputs
// assumes the 36-bit organisation (four lanes) and the controller model
`timescale 1ns/100ps
module tb_top
   import burst_sram_pkg::*;
;
   logic clk, reset, order_n, oe_n, cs_n, ps_n, cs_strobe_n, step_n, gw_n, gate_n;
   logic [3:0] ln_n;
   logic [1:0] a_lo, burst_addr;
   logic [3:0] lane_write_en, lane_drive_en;
   logic mem_read, cycle_active;
   cycle_kind_t cycle_kind;
   int miscompares = 0;
   int tests_run = 0;
   ctrl_model ctrl_model_i (.clk(clk), .chip_select_n(cs_n), .proc_addr_strobe_n(ps_n),
      .ctrl_addr_strobe_n(cs_strobe_n), .burst_step_n(step_n), .all_lane_write_n(gw_n),
      .lane_write_gate_n(gate_n), .lane_write_n(ln_n), .addr_low_bits(a_lo));
   sync_burst_sram_control sync_burst_sram_control_i (.clk(clk), .reset(reset),
      .chip_select_n(cs_n), .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(cs_strobe_n),
      .burst_step_n(step_n), .all_lane_write_n(gw_n), .lane_write_gate_n(gate_n),
      .lane_write_n(ln_n), .burst_order_sel_n(order_n), .output_enable_n(oe_n),
      .addr_low_bits(a_lo), .burst_addr(burst_addr), .lane_write_en(lane_write_en),
      .mem_read(mem_read), .lane_drive_en(lane_drive_en), .cycle_active(cycle_active),
      .cycle_kind(cycle_kind));
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // compare every output at once, address skipped on deselect; callers sample 1 ns after an edge
   task automatic expect_now(input cycle_kind_t ek, input logic [1:0] ea, input logic [3:0] ewe,
      input logic erd, input logic [3:0] edrv);
      tests_run++;
      if (cycle_kind !== ek || (ek != CYC_DESELECT && burst_addr !== ea) || lane_write_en !== ewe
         || mem_read !== erd || lane_drive_en !== edrv || cycle_active !== (ek != CYC_DESELECT)) begin
         miscompares++;
         $display("BAD %0t kind %h addr %h we %h rd %b drv %h", $time, cycle_kind, burst_addr,
            lane_write_en, mem_read, lane_drive_en);
      end
   endtask
   // issue one cycle and check the registered answer
   task automatic op(input logic [5:0] c, input logic [3:0] ln, input logic [1:0] a,
      input cycle_kind_t ek, input logic [1:0] ea, input logic [3:0] ewe, input logic erd,
      input logic [3:0] edrv);
      ctrl_model_i.drive(c, ln, a);
      @(posedge clk);
      #1;
      expect_now(ek, ea, ewe, erd, edrv);
   endtask
   // watchdog
   initial begin
      #10000;
      miscompares++;
      stop_test();
   end
   // main sequence
   initial begin
      logic [3:0] p;
      reset = 1'b1;
      order_n = 1'b0;
      oe_n = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      expect_now(CYC_DESELECT, 2'h0, 4'h0, 1'b0, 4'h0);
      @(negedge clk) reset = 1'b0;
      // linear burst begun by processor strobe with write inputs asserted
      op(6'b001100, 4'h0, 2'h1, CYC_BEGIN_RD, 2'h1, 4'h0, 1'b1, 4'hf);
      for (int i = 1; i <= 3; i++) begin
         op(6'b011011, 4'hf, 2'h0, CYC_CONTINUE, 2'(1 + i), 4'h0, 1'b1, 4'hf);
      end
      // fifth beat wraps to start as a dummy read: drivers off, counter still steps
      ctrl_model_i.drive(6'b011011, 4'hf, 2'h0);
      oe_n = 1'b1;
      @(posedge clk);
      #1;
      expect_now(CYC_CONTINUE, 2'h1, 4'h0, 1'b1, 4'h0);
      op(6'b110111, 4'hf, 2'h0, CYC_DESELECT, 2'h0, 4'h0, 1'b0, 4'h0);
      $display("test linear done");
      @(negedge clk);
      order_n = 1'b1;
      oe_n = 1'b0;
      // interleaved burst begun by controller strobe, continued while deselected
      op(6'b010111, 4'hf, 2'h2, CYC_BEGIN_RD, 2'h2, 4'h0, 1'b1, 4'hf);
      for (int i = 1; i <= 4; i++) op(6'b111011, 4'hf, 2'h0, CYC_CONTINUE, 2'(2 ^ i), 4'h0, 1'b1, 4'hf);
      op(6'b011111, 4'hf, 2'h0, CYC_SUSPEND, 2'h2, 4'h0, 1'b1, 4'hf);
      // drivers off, then a held suspend write and a continue write, global write low
      @(negedge clk);
      oe_n = 1'b1;
      op(6'b011101, 4'hf, 2'h0, CYC_SUSPEND, 2'h2, 4'hf, 1'b0, 4'h0);
      op(6'b011001, 4'hf, 2'h0, CYC_CONTINUE, 2'h3, 4'hf, 1'b0, 4'h0);
      $display("test interleaved done");
      // dummy read with drivers off, then writes without a deselect
      op(6'b011011, 4'hf, 2'h0, CYC_CONTINUE, 2'h0, 4'h0, 1'b1, 4'h0);
      for (int k = 0; k < 7; k++) begin
         p = (k < 4) ? 4'(1 << k) : ((k == 4) ? 4'h5 : ((k == 5) ? 4'hf : 4'h0));
         op(6'b010110, ~p, 2'h3, (p != 4'h0) ? CYC_BEGIN_WR : CYC_BEGIN_RD, 2'h3, p, p == 4'h0, 4'h0);
      end
      op(6'b010111, 4'h0, 2'h1, CYC_BEGIN_RD, 2'h1, 4'h0, 1'b1, 4'h0);
      $display("test lanes done");
      // output enable acts with no clock edge
      @(negedge clk);
      oe_n = 1'b0;
      #1;
      expect_now(CYC_BEGIN_RD, 2'h1, 4'h0, 1'b1, 4'hf);
      @(negedge clk);
      oe_n = 1'b1;
      #1;
      expect_now(CYC_BEGIN_RD, 2'h1, 4'h0, 1'b1, 4'h0);
      // global write overrides gate and lanes
      op(6'b010101, 4'hf, 2'h2, CYC_BEGIN_WR, 2'h2, 4'hf, 1'b0, 4'h0);
      $display("test enable and global write done");
      stop_test();
   end
endmodule
